// File: pmwc_consts.svh
// offsets, field positions, reset values and timing of the power-mode block
`ifndef PMWC_CONSTS_SVH
`define PMWC_CONSTS_SVH
// register word offsets
`define PMWC_A_CRYCTL 3'h0
`define PMWC_A_SYSCLK 3'h1
`define PMWC_A_HFRC 3'h2
`define PMWC_A_HFX 3'h3
`define PMWC_A_PAWAKE 3'h4
`define PMWC_A_STAT 3'h5
// crystal control fields
`define PMWC_CRY_EN 0
`define PMWC_CRY_OK 1
`define PMWC_CRY_SP 2
// system clock control fields
`define PMWC_SC_SIDLE 0
`define PMWC_SC_HIDLE 1
`define PMWC_SC_SSRC 2
`define PMWC_SC_HSRC 3
`define PMWC_SC_DIV_LO 5
`define PMWC_SC_DIV_HI 7
`define PMWC_DIV_SLOW 3'h7
// high-speed oscillator control fields
`define PMWC_HF_EN 0
`define PMWC_HF_OK 1
`define PMWC_HF_FS_LO 2
`define PMWC_HF_FS_HI 3
// status fields
`define PMWC_ST_PDOWN 0
`define PMWC_ST_WDEXP 1
`define PMWC_ST_MODE_LO 2
`define PMWC_ST_MODE_HI 4
`define PMWC_ST_SLOW 5
`define PMWC_ST_SWITCH 6
// reset values
`define PMWC_RST_CRYCTL 8'h00
`define PMWC_RST_SYSCLK 8'h00
`define PMWC_RST_HFRC 8'h01
`define PMWC_RST_HFX 8'h00
`define PMWC_RST_PAWAKE 8'h00
// timing: clock rate and oscillator settle times in microseconds
`define PMWC_CLK_MHZ 40
`define PMWC_CRY_SPUP_US 100
`define PMWC_CRY_LP_US 1000
`define PMWC_HFRC_US 16
`define PMWC_HFX_US 1000
`endif

// File: pmwc_pkg.sv
// types shared by the power-mode and wake-up block
package pmwc_pkg;
    // halt state of the core
    typedef enum logic [2:0] {
        PMWC_RUN = 3'b000,
        PMWC_SLEEP = 3'b001,
        PMWC_NAP_LOW = 3'b010,
        PMWC_NAP_BOTH = 3'b011,
        PMWC_NAP_HIGH = 3'b100
    } pmwc_mode_e;
    // system clock selection as seen by the clock tree
    typedef struct packed {
        logic fast;
        logic [2:0] div;
        logic hs_src;
        logic ls_src;
    } pmwc_clksel_s;
endpackage

// File: pmwc_top.sv
// power mode, clock switching and wake-up control
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "pmwc_consts.svh"

module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int unsigned PA_W = 8,
    parameter int unsigned IRQ_W = 4,
    parameter int unsigned CNT_W = 20,
    parameter logic [CNT_W-1:0] CRY_FAST_CYC =
        CNT_W'(`PMWC_CRY_SPUP_US * `PMWC_CLK_MHZ),
    parameter logic [CNT_W-1:0] CRY_SLOW_CYC =
        CNT_W'(`PMWC_CRY_LP_US * `PMWC_CLK_MHZ),
    parameter logic [CNT_W-1:0] HFRC_CYC =
        CNT_W'(`PMWC_HFRC_US * `PMWC_CLK_MHZ),
    parameter logic [CNT_W-1:0] HFX_CYC =
        CNT_W'(`PMWC_HFX_US * `PMWC_CLK_MHZ)
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic halt_exec,
    input wire logic clr_wdt,
    input wire logic wdt_overflow,
    input wire logic stack_full,
    input wire logic [IRQ_W-1:0] irq_req,
    input wire logic [IRQ_W-1:0] irq_en,
    input wire logic init_pin_n,
    input wire logic [PA_W-1:0] port_a,
    output logic cpu_run,
    output logic wdt_clear,
    output logic full_reset_req,
    output logic pc_sp_reset,
    output logic irq_vector,
    output pmwc_clksel_s clk_sel,
    output logic clk_switching,
    output logic hs_clk_on,
    output logic ls_clk_on,
    output logic cry_run,
    output logic cry_speedup,
    output logic hfrc_run,
    output logic hfx_run
);

    // ************************************************
    // reset and pin synchronisers
    // ************************************************
    logic [1:0] rst_pipe_q;
    logic rst_sync_n;

    // release reset through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    logic [PA_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_lvl_q;
    logic [2:0] ini_s_q;
    logic ini_lvl_q;

    // three flops; a level counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_s3_q <= '1;
            pa_lvl_q <= '1;
            ini_s_q <= 3'h7;
            ini_lvl_q <= 1'b1;
        end else begin
            pa_s1_q <= port_a;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pa_lvl_q <= (pa_s2_q & pa_s3_q) | (pa_lvl_q & (pa_s2_q | pa_s3_q));
            ini_s_q <= {ini_s_q[1:0], init_pin_n};
            ini_lvl_q <= (ini_s_q[1] & ini_s_q[2])
                | (ini_lvl_q & (ini_s_q[1] | ini_s_q[2]));
        end
    end

    // ************************************************
    // software registers
    // ************************************************
    logic cry_en_q, cry_sp_q;
    logic [2:0] div_q;
    logic hsrc_q, ssrc_q, hidle_q, sidle_q;
    logic [1:0] hfrc_fs_q;
    logic hfrc_en_q, hfx_en_q;
    logic [PA_W-1:0] pawake_q;
    logic wr_cry, wr_sys, wr_hfrc, wr_hfx, wr_pa;
    // reset words held as vectors, so that single fields can be picked out of them
    localparam logic [7:0] RST_CRY = `PMWC_RST_CRYCTL;
    localparam logic [7:0] RST_SC = `PMWC_RST_SYSCLK;
    localparam logic [7:0] RST_HFRC = `PMWC_RST_HFRC;
    localparam logic [7:0] RST_HFX = `PMWC_RST_HFX;

    // address decode of the write port
    always_comb begin
        wr_cry = 1'b0;
        wr_sys = 1'b0;
        wr_hfrc = 1'b0;
        wr_hfx = 1'b0;
        wr_pa = 1'b0;
        if (reg_addr == `PMWC_A_CRYCTL) begin
            wr_cry = reg_wr;
        end else if (reg_addr == `PMWC_A_SYSCLK) begin
            wr_sys = reg_wr;
        end else if (reg_addr == `PMWC_A_HFRC) begin
            wr_hfrc = reg_wr;
        end else if (reg_addr == `PMWC_A_HFX) begin
            wr_hfx = reg_wr;
        end else if (reg_addr == `PMWC_A_PAWAKE) begin
            wr_pa = reg_wr;
        end
    end

    // writable fields; stable flags and status are hardware-owned
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cry_en_q <= RST_CRY[`PMWC_CRY_EN];
            cry_sp_q <= RST_CRY[`PMWC_CRY_SP];
            div_q <= RST_SC[`PMWC_SC_DIV_HI:`PMWC_SC_DIV_LO];
            hsrc_q <= RST_SC[`PMWC_SC_HSRC];
            ssrc_q <= RST_SC[`PMWC_SC_SSRC];
            hidle_q <= RST_SC[`PMWC_SC_HIDLE];
            sidle_q <= RST_SC[`PMWC_SC_SIDLE];
            hfrc_fs_q <= RST_HFRC[`PMWC_HF_FS_HI:`PMWC_HF_FS_LO];
            hfrc_en_q <= RST_HFRC[`PMWC_HF_EN];
            hfx_en_q <= RST_HFX[`PMWC_HF_EN];
            pawake_q <= PA_W'(`PMWC_RST_PAWAKE);
        end else begin
            if (wr_cry) begin
                cry_en_q <= reg_wdata[`PMWC_CRY_EN];
                cry_sp_q <= reg_wdata[`PMWC_CRY_SP];
            end
            if (wr_sys) begin
                div_q <= reg_wdata[`PMWC_SC_DIV_HI:`PMWC_SC_DIV_LO];
                hsrc_q <= reg_wdata[`PMWC_SC_HSRC];
                ssrc_q <= reg_wdata[`PMWC_SC_SSRC];
                hidle_q <= reg_wdata[`PMWC_SC_HIDLE];
                sidle_q <= reg_wdata[`PMWC_SC_SIDLE];
            end
            if (wr_hfrc) begin
                hfrc_fs_q <= reg_wdata[`PMWC_HF_FS_HI:`PMWC_HF_FS_LO];
                hfrc_en_q <= reg_wdata[`PMWC_HF_EN];
            end
            if (wr_hfx) begin
                hfx_en_q <= reg_wdata[`PMWC_HF_EN];
            end
            if (wr_pa) begin
                pawake_q <= reg_wdata[PA_W-1:0];
            end
        end
    end

    // ************************************************
    // halt modes
    // ************************************************
    pmwc_mode_e mode_q;
    logic running, halt_go, hs_ok, ls_ok;

    assign running = (mode_q == PMWC_RUN);
    assign halt_go = running & halt_exec;
    // fast clock stops in sleep and slow-only nap; slow in sleep, fast-only nap
    assign hs_ok = (mode_q != PMWC_SLEEP) && (mode_q != PMWC_NAP_LOW);
    assign ls_ok = (mode_q != PMWC_SLEEP) && (mode_q != PMWC_NAP_HIGH);

    // ************************************************
    // oscillator settling: crystal, fast RC, fast crystal
    // ************************************************
    pmwc_clksel_s cur_q, tgt;
    logic [2:0] osc_on, osc_on_q, osc_rst, ok_q;
    logic [CNT_W-1:0] cnt_q [3];
    logic [CNT_W-1:0] lim [3];
    logic need_rc, need_x;

    // outside sleep and slow-only nap, fast sources run when enabled, or while the clock tree needs them
    assign need_rc = (cur_q.fast & ~cur_q.hs_src) | (tgt.fast & ~tgt.hs_src);
    assign need_x = (cur_q.fast & cur_q.hs_src) | (tgt.fast & tgt.hs_src);
    assign osc_on[0] = cry_en_q;
    assign osc_on[1] = hs_ok & (hfrc_en_q | need_rc);
    assign osc_on[2] = hs_ok & (hfx_en_q | need_x);
    // a fresh start, or a new RC frequency, drops the flag until settled
    assign osc_rst[0] = osc_on[0] & ~osc_on_q[0];
    assign osc_rst[1] = (osc_on[1] & ~osc_on_q[1])
        | (wr_hfrc & (reg_wdata[`PMWC_HF_FS_HI:`PMWC_HF_FS_LO] != hfrc_fs_q));
    assign osc_rst[2] = osc_on[2] & ~osc_on_q[2];
    assign lim[0] = cry_sp_q ? CRY_FAST_CYC : CRY_SLOW_CYC;
    assign lim[1] = HFRC_CYC;
    assign lim[2] = HFX_CYC;

    // one settle counter per oscillator
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_on_q <= 3'h0;
            ok_q <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            osc_on_q <= osc_on;
            for (int i = 0; i < 3; i++) begin
                if (!osc_on[i] || osc_rst[i]) begin
                    cnt_q[i] <= '0;
                    ok_q[i] <= 1'b0;
                end else if (cnt_q[i] >= lim[i]) begin
                    ok_q[i] <= 1'b1;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // ************************************************
    // clock switching
    // ************************************************
    logic tgt_ok, cur_ok;

    // target from the divider code; 111 means the slow source
    always_comb begin
        tgt.fast = (div_q != `PMWC_DIV_SLOW);
        tgt.div = div_q;
        tgt.hs_src = hsrc_q;
        tgt.ls_src = ssrc_q;
    end
    assign tgt_ok = tgt.fast ? (tgt.hs_src ? ok_q[2] : ok_q[1])
        : (tgt.ls_src ? ok_q[0] : 1'b1);
    assign cur_ok = cur_q.fast ? (cur_q.hs_src ? ok_q[2] : ok_q[1])
        : (cur_q.ls_src ? ok_q[0] : 1'b1);
    assign clk_switching = (tgt != cur_q);

    // the old source stays until the new one is stable, so no runt pulses
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            // tree leaves reset on the fast RC, divide by one, as the select word says
            cur_q <= '{fast: 1'b1, div: 3'h0, hs_src: 1'b0, ls_src: 1'b0};
        end else if (clk_switching && tgt_ok) begin
            cur_q <= tgt;
        end
    end

    // ************************************************
    // wake sources
    // ************************************************
    logic [IRQ_W-1:0] blk_q, irq_new;
    logic [PA_W-1:0] pa_fall;
    logic ini_fall, irq_wake, irq_take, wake;

    assign pa_fall = pawake_q & pa_lvl_q & ~pa_s2_q & ~pa_s3_q;
    assign ini_fall = ini_lvl_q & ~ini_s_q[1] & ~ini_s_q[2];
    assign irq_new = irq_req & ~blk_q;
    assign irq_wake = |irq_new;
    assign irq_take = |(irq_new & irq_en) & ~stack_full;
    assign wake = ini_fall | (|pa_fall) | irq_wake | wdt_overflow;

    // requests already standing at halt are blocked for that halt
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blk_q <= '0;
        end else if (halt_go) begin
            blk_q <= irq_req;
        end
    end

    // halt state machine
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_q <= PMWC_RUN;
        end else begin
            case (mode_q)
                PMWC_RUN: begin
                    if (halt_exec) begin
                        case ({hidle_q, sidle_q})
                            2'b00: mode_q <= PMWC_SLEEP;
                            2'b01: mode_q <= PMWC_NAP_LOW;
                            2'b11: mode_q <= PMWC_NAP_BOTH;
                            default: mode_q <= PMWC_NAP_HIGH;
                        endcase
                    end
                end
                default: begin
                    if (wake) begin
                        mode_q <= PMWC_RUN;
                    end
                end
            endcase
        end
    end

    // ************************************************
    // flags and pulses to the core
    // ************************************************
    logic pdown_q, wdexp_q;

    // power-down flag; the halt set wins over a clear
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pdown_q <= 1'b0;
        end else if (halt_go) begin
            pdown_q <= 1'b1;
        end else if (clr_wdt) begin
            pdown_q <= 1'b0;
        end
    end

    // expiry flag; an overflow set wins over the halt clear
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdexp_q <= 1'b0;
        end else if (wdt_overflow) begin
            wdexp_q <= 1'b1;
        end else if (halt_go) begin
            wdexp_q <= 1'b0;
        end
    end

    // one-cycle requests to the core, watchdog and reset logic
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_clear <= 1'b0;
            full_reset_req <= 1'b0;
            pc_sp_reset <= 1'b0;
            irq_vector <= 1'b0;
        end else begin
            wdt_clear <= halt_go | clr_wdt;
            full_reset_req <= ini_fall | (running & wdt_overflow);
            pc_sp_reset <= ~running & wdt_overflow;
            irq_vector <= ~running & ~ini_fall & ~wdt_overflow & irq_take;
        end
    end

    // core runs only once awake and its clock source is settled
    assign cpu_run = running & cur_ok;
    assign clk_sel = cur_q;
    assign hs_clk_on = hs_ok & (cur_q.fast ? (cur_q.hs_src ? ok_q[2] : ok_q[1]) : 1'b1);
    assign ls_clk_on = ls_ok;
    assign cry_run = cry_en_q;
    assign cry_speedup = cry_sp_q;
    assign hfrc_run = osc_on[1];
    assign hfx_run = osc_on[2];

    // ************************************************
    // read port, data one cycle after the strobe
    // ************************************************
    logic [7:0] rd_d;

    // unmapped offsets read zero
    always_comb begin
        rd_d = 8'h00;
        if (reg_addr == `PMWC_A_CRYCTL) begin
            rd_d[`PMWC_CRY_EN] = cry_en_q;
            rd_d[`PMWC_CRY_OK] = ok_q[0];
            rd_d[`PMWC_CRY_SP] = cry_sp_q;
        end else if (reg_addr == `PMWC_A_SYSCLK) begin
            rd_d = {div_q, 1'b0, hsrc_q, ssrc_q, hidle_q, sidle_q};
        end else if (reg_addr == `PMWC_A_HFRC) begin
            rd_d = {4'h0, hfrc_fs_q, ok_q[1], hfrc_en_q};
        end else if (reg_addr == `PMWC_A_HFX) begin
            rd_d = {6'h00, ok_q[2], hfx_en_q};
        end else if (reg_addr == `PMWC_A_PAWAKE) begin
            rd_d[PA_W-1:0] = pawake_q;
        end else if (reg_addr == `PMWC_A_STAT) begin
            rd_d[`PMWC_ST_PDOWN] = pdown_q;
            rd_d[`PMWC_ST_WDEXP] = wdexp_q;
            rd_d[`PMWC_ST_MODE_HI:`PMWC_ST_MODE_LO] = mode_q;
            rd_d[`PMWC_ST_SLOW] = ~cur_q.fast;
            rd_d[`PMWC_ST_SWITCH] = clk_switching;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    a_sleep_entry:
    assert property (halt_go && !hidle_q && !sidle_q |=> mode_q == PMWC_SLEEP && !hs_clk_on)
        else $error("sleep not entered");
    a_nap_low:
    assert property (halt_go && !hidle_q && sidle_q |=> !hs_clk_on && ls_clk_on)
        else $error("slow-only nap wrong");
    a_nap_both:
    assert property (halt_go && hidle_q && sidle_q |=> mode_q == PMWC_NAP_BOTH && !cpu_run)
        else $error("both-clock nap wrong");
    a_nap_high:
    assert property (halt_go && hidle_q && !sidle_q |=> hs_ok && !ls_clk_on)
        else $error("fast-only nap wrong");
    a_halt_flags:
    assert property (halt_go && !wdt_overflow |=> pdown_q && !wdexp_q && wdt_clear)
        else $error("halt flags wrong");
    a_cry_restart:
    assert property ($rose(cry_en_q) |-> !ok_q[0] ##1 !ok_q[0])
        else $error("crystal flag not dropped");
    a_cry_enable:
    assert property (wr_cry |=> cry_run == $past(reg_wdata[`PMWC_CRY_EN]))
        else $error("crystal enable wrong");
    a_switch_safe:
    assert property ($changed(cur_q) |-> $past(tgt_ok))
        else $error("switch before source stable");
    a_port_wake:
    assert property (!running && |pa_fall |=> running ##1 !pc_sp_reset)
        else $error("port wake failed");
    a_stale_irq:
    assert property (!running && irq_req == blk_q && !wdt_overflow && !ini_fall
        && !(|pa_fall) |=> !running)
        else $error("stale request woke");
    a_wdt_wake:
    assert property (!running && wdt_overflow |=> pc_sp_reset && wdexp_q && running)
        else $error("watchdog wake wrong");

    c_sleep_wake: cover property (mode_q == PMWC_SLEEP ##1 running);
    c_go_slow: cover property ($fell(cur_q.fast));
    c_irq_vec: cover property (irq_vector);

endmodule // pmwc_top

// File: pmwc_core_model.sv
// cpu core stand-in that executes halt and clear-watchdog instructions
`timescale 1ns/1ps
module pmwc_core_model (
    input wire logic sys_clk,
    input wire logic cpu_run,
    output logic halt_exec,
    output logic clr_wdt
);
    initial begin
        halt_exec = 1'b0;
        clr_wdt = 1'b0;
    end
    // halt once clocked from a settled source, or after 500 cycles without one, so a stalled wake stays visible
    task automatic do_halt();
        for (int n = 0; n < 500 && cpu_run !== 1'b1; n++) @(posedge sys_clk);
        @(posedge sys_clk);
        halt_exec <= 1'b1;
        @(posedge sys_clk);
        halt_exec <= 1'b0;
    endtask
    // single clear-watchdog instruction
    task automatic do_clr();
        @(posedge sys_clk);
        clr_wdt <= 1'b1;
        @(posedge sys_clk);
        clr_wdt <= 1'b0;
    endtask
endmodule // pmwc_core_model

// File: tb.sv
// self-checking bench for the power-mode and wake-up block
`timescale 1ns/1ps
`include "pmwc_consts.svh"
module tb import pmwc_pkg::*;;
    logic sys_clk, rst_n, reg_wr, reg_rd, wdt_overflow, stack_full, init_pin_n;
    logic halt_exec, clr_wdt, cpu_run, wdt_clear, full_reset_req, pc_sp_reset, irq_vector;
    logic clk_switching, hs_clk_on, ls_clk_on, cry_run, cry_speedup, hfrc_run, hfx_run;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, port_a;
    logic [3:0] irq_req, irq_en;
    pmwc_clksel_s clk_sel;
    int n_mismatch = 0, comparisons = 0, cyc = 0, nv = 0, np = 0, nf = 0, nw = 0, s0, s1;
    // rows: {high idle, low idle, mode code, fast gate, slow gate}
    logic [6:0] rows [4] = '{7'b00_001_00, 7'b01_010_01, 7'b11_011_11, 7'b10_100_10};

    // short settle counts keep the run brief
    pmwc_top #(.CRY_FAST_CYC(20'd8), .CRY_SLOW_CYC(20'd24), .HFRC_CYC(20'd10),
        .HFX_CYC(20'd12)) dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .halt_exec, .clr_wdt, .wdt_overflow, .stack_full, .irq_req, .irq_en,
        .init_pin_n, .port_a, .cpu_run, .wdt_clear, .full_reset_req, .pc_sp_reset,
        .irq_vector, .clk_sel, .clk_switching, .hs_clk_on, .ls_clk_on, .cry_run,
        .cry_speedup, .hfrc_run, .hfx_run);
    pmwc_core_model core (.sys_clk, .cpu_run, .halt_exec, .clr_wdt);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // pulse counters on the falling edge, away from the launching edge; also the hang guard
    always @(negedge sys_clk) begin
        cyc++;
        nv += int'(irq_vector === 1'b1);
        np += int'(pc_sp_reset === 1'b1);
        nf += int'(full_reset_req === 1'b1);
        nw += int'(wdt_clear === 1'b1);
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(logic [2:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_run();
        for (int n = 0; n < 300 && cpu_run !== 1'b1; n++) @(negedge sys_clk);
        chk("cpu_run", {7'h00, cpu_run}, 8'h01);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        {rst_n, reg_wr, reg_rd, wdt_overflow, stack_full, reg_addr, reg_wdata} = '0;
        {init_pin_n, port_a, irq_req, irq_en} = {1'b1, 8'hff, 8'h00};
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        wait_run();
        // status is read-only; unmapped words read zero
        wr(`PMWC_A_STAT, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            chk("reset value", d, (a == 2) ? 8'h03 : 8'h00);
        end
        $display("test reset done");
        // each halt mode, woken by watchdog overflow
        foreach (rows[i]) begin
            {s0, s1} = {nw, np};
            wr(`PMWC_A_SYSCLK, {6'h00, rows[i][6:5]});
            core.do_halt();
            tick(1);
            chk("gates", {6'h00, hs_clk_on, ls_clk_on}, {6'h00, rows[i][1:0]});
            chk("rc run", {7'h00, hfrc_run}, {7'h00, rows[i][1]});
            rd(`PMWC_A_STAT);
            chk("halt status", {3'h0, d[4:0]}, {3'h0, rows[i][4:2], 2'b01});
            chk("wdt clear", 8'(nw - s0), 8'h01);
            @(posedge sys_clk);
            wdt_overflow <= 1'b1;
            @(posedge sys_clk);
            wdt_overflow <= 1'b0;
            wait_run();
            rd(`PMWC_A_STAT);
            chk("wdt wake status", {3'h0, d[4:0]}, 8'h03);
            chk("pc sp reset", 8'(np - s1), 8'h01);
            core.do_clr();
            rd(`PMWC_A_STAT);
            chk("pdown clear", {7'h00, d[0]}, 8'h00);
            $display("test halt row %0d done", i);
        end
        // crystal: quick settle with speed-up, slow settle without
        wr(`PMWC_A_CRYCTL, 8'h05);
        tick(1);
        chk("cry run", {6'h00, cry_speedup, cry_run}, 8'h03);
        rd(`PMWC_A_CRYCTL);
        chk("cry flag low", d, 8'h05);
        tick(12);
        rd(`PMWC_A_CRYCTL);
        chk("cry fast settle", d, 8'h07);
        wr(`PMWC_A_CRYCTL, 8'h00);
        tick(1);
        chk("cry stop", {7'h00, cry_run}, 8'h00);
        wr(`PMWC_A_CRYCTL, 8'h01);
        tick(12);
        rd(`PMWC_A_CRYCTL);
        chk("cry slow pending", d, 8'h01);
        tick(24);
        rd(`PMWC_A_CRYCTL);
        chk("cry slow settle", d, 8'h03);
        $display("test crystal done");
        // crystal setting left untouched while it clocks the system
        wr(`PMWC_A_SYSCLK, 8'he4);
        tick(1);
        for (int n = 0; n < 300 && clk_switching !== 1'b0; n++) @(negedge sys_clk);
        chk("slow sel", {6'h00, clk_sel.fast, clk_sel.ls_src}, 8'h01);
        wr(`PMWC_A_SYSCLK, 8'h60);
        tick(1);
        for (int n = 0; n < 300 && clk_switching !== 1'b0; n++) @(negedge sys_clk);
        chk("fast sel", {4'h0, clk_sel.fast, clk_sel.div}, 8'h0b);
        // fast crystal starts on demand; the tree stays on the RC until its flag sets
        wr(`PMWC_A_SYSCLK, 8'h08);
        tick(1);
        chk("hfx start", {6'h00, hfx_run, clk_sel.hs_src}, 8'h02);
        for (int n = 0; n < 300 && clk_switching !== 1'b0; n++) @(negedge sys_clk);
        chk("hfx sel", {6'h00, hfx_run, clk_sel.hs_src}, 8'h03);
        rd(`PMWC_A_HFX);
        chk("hfx flag", d, 8'h02);
        $display("test clock switch done");
        // port A: disabled pin ignored, enabled pin wakes without vector
        wr(`PMWC_A_PAWAKE, 8'h04);
        wr(`PMWC_A_SYSCLK, 8'h63);
        s0 = nv;
        core.do_halt();
        port_a <= 8'hf7;
        tick(8);
        chk("no wake", {7'h00, cpu_run}, 8'h00);
        @(posedge sys_clk);
        port_a <= 8'hf3;
        wait_run();
        chk("no vector", 8'(nv - s0), 8'h00);
        $display("test port wake done");
        // interrupts: stale request, enabled new one, stack full
        @(posedge sys_clk);
        {irq_en, irq_req} <= 8'h31;
        core.do_halt();
        tick(8);
        chk("stale irq", {7'h00, cpu_run}, 8'h00);
        @(posedge sys_clk);
        irq_req <= 4'h3;
        wait_run();
        tick(2);
        chk("vector", 8'(nv - s0), 8'h01);
        @(posedge sys_clk);
        {stack_full, irq_req} <= 5'h10;
        core.do_halt();
        irq_req <= 4'h2;
        wait_run();
        tick(3);
        chk("stack full", 8'(nv - s0), 8'h01);
        $display("test irq wake done");
        // init pin during halt asks for a full reset
        s0 = nf;
        core.do_halt();
        init_pin_n <= 1'b0;
        tick(8);
        chk("full reset", 8'(nf - s0), 8'h01);
        $display("test init pin done");
        end_sim();
    end
endmodule // tb
